/* frs_checker.sv */
// Port checker for the frame readback sequencer
module frs_checker #(
  parameter FRAME_WORDS = 14
) (
  input logic        clk,
  input logic        rst_n,
  input logic        ce,
  input logic        cfg_in_ready,
  input logic [31:0] cfg_mem_addr,
  input logic        rb_valid,
  input logic        rb_ready,
  input logic [31:0] rb_data,
  input logic        rb_busy,
  input logic [3:0]  map_lut_bit,
  input logic        map_slice,
  input logic [15:0] map_frame_bit_index,
  input logic [7:0]  map_major,
  input logic [7:0]  map_minor_address,
  input logic [15:0] map_frame_word_number,
  input logic [4:0]  map_word_bit_position,
  input logic [31:0] map_frame_start_word
);
  // ----------------------------------------------------------
  // Timing frame
  // ----------------------------------------------------------
  localparam logic [31:0] FW = FRAME_WORDS;  // Words per frame
  logic upd_r;                               // Mapper saw an enabled edge
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Low on the first edge after reset, as inputs then were sampled in reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      upd_r <= 1'b0;
    end else begin
      upd_r <= ce;
    end
  end
  // ----------------------------------------------------------
  // Mapper and stream
  // ----------------------------------------------------------
  a_minor_slice0: assert property (upd_r && !$past(map_slice) |->
    map_minor_address == 8'($past(map_lut_bit)) + 8'h20) else $error("minor slice 0");
  a_minor_slice1: assert property (upd_r && $past(map_slice) |->
    map_minor_address == 8'h0F - 8'($past(map_lut_bit))) else $error("minor slice 1");
  a_word_number: assert property (upd_r |->
    map_frame_word_number == $past(map_frame_bit_index) >> 5) else $error("word number");
  a_bit_position: assert property (upd_r |->
    map_word_bit_position == 5'h1F - 5'($past(map_frame_bit_index))) else $error("bit pos");
  a_start_word: assert property (upd_r && $past(map_major) != 8'h00 |->
    map_frame_start_word == FW * (32'd8 + (32'($past(map_major)) - 32'd1) * 32'd48
    + 32'(map_minor_address)) + FW) else $error("start word");
  a_busy_blocks: assert property (rb_busy |-> !cfg_in_ready) else $error("ready in run");
  a_addr_ascend: assert property ($past(rb_busy) && rb_busy &&
    cfg_mem_addr != $past(cfg_mem_addr) |-> cfg_mem_addr == $past(cfg_mem_addr) + 32'd1)
    else $error("fetch not ascending");
  a_data_holds: assert property (rb_valid && !rb_ready |=>
    rb_valid && $stable(rb_data)) else $error("readback word dropped");
  c_run_start: cover property ($rose(rb_busy));
  c_run_end: cover property ($fell(rb_busy));
  c_stall: cover property (rb_valid && !rb_ready ##1 rb_valid && rb_ready);
endmodule
bind frs_sequencer frs_checker #(.FRAME_WORDS(FRAME_WORDS)) u_frs_chk (
  .clk(clk), .rst_n(rst_n), .ce(ce), .cfg_in_ready(cfg_in_ready),
  .cfg_mem_addr(cfg_mem_addr), .rb_valid(rb_valid), .rb_ready(rb_ready),
  .rb_data(rb_data), .rb_busy(rb_busy), .map_lut_bit(map_lut_bit),
  .map_slice(map_slice), .map_frame_bit_index(map_frame_bit_index),
  .map_major(map_major), .map_minor_address(map_minor_address),
  .map_frame_word_number(map_frame_word_number),
  .map_word_bit_position(map_word_bit_position),
  .map_frame_start_word(map_frame_start_word));

/* frs_defines.vh */
// Constants for the frame readback sequencer
//
// Notes on behaviour
// - Frames stream out in ascending address order
// - One run of frames starts with one pad
// - Frame is 14 words plus pad frame
// - Minor address from table bit and slice
// - Slice one bits reverse across frames
// - Bit index maps to word and position
// - Table bits read back complemented
`ifndef FRS_DEFINES_VH
`define FRS_DEFINES_VH
// ------------------------------------------------------------
// Packet words
// ------------------------------------------------------------
`define FRS_SYNC_WORD     32'hAA995566
`define FRS_HDR_FAR_WR    32'h30002001
`define FRS_HDR_CMD_WR    32'h30008001
`define FRS_CMD_READ_CONFIGURATION_COMMAND      32'h00000004
`define FRS_HDR_FRAME_DATA_OUTPUT_REGISTER_RD   32'h28006000
`define FRS_HDR_RD_MASK   32'hFFFFF800
`define FRS_HDR2_TYPE     32'h48000000
`define FRS_HDR2_MASK     32'hF8000000
// ------------------------------------------------------------
// Frame address fields
// ------------------------------------------------------------
`define FRS_MAJ_LSB       17
`define FRS_MAJ_W         8
`define FRS_MIN_LSB       9
`define FRS_MIN_W         8
// ------------------------------------------------------------
// Geometry and address arithmetic
// ------------------------------------------------------------
`define FRS_FRAME_WORDS   14
`define FRS_LUT_OFS       32
`define FRS_SLICE1_BASE   15
`define FRS_COL_FRAMES    48
`define FRS_LEAD_FRAMES   8
`define FRS_WORD_BITS     32
`define FRS_FIFO_DEPTH    4
`endif

/* frs_fifo.v */
// Readback FIFO module sits in frs_sequencer.v, so one file holds all the logic

/* frs_host.sv */
// Host model: sends readback packets and collects returned words
`include "frs_defines.vh"
module frs_host (
  input  logic        clk,
  input  logic        ce,
  input  logic        cfg_in_ready,
  output logic        cfg_in_valid,
  output logic [31:0] cfg_in_data,
  input  logic        rb_valid,
  input  logic [31:0] rb_data,
  output logic        rb_ready,
  input  logic        slow
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] got[$];        // Words taken from the readback port
  integer      seed = 44797;  // Fixed seed for stall pattern
  initial begin
    cfg_in_valid = 1'b0;
    cfg_in_data  = 32'h0;
    rb_ready     = 1'b0;
  end
  // Consumer stalls at random, hard when slow, to fill the FIFO
  always @(posedge clk) begin
    if (rb_valid && rb_ready && ce) begin
      got.push_back(rb_data);
    end
    rb_ready <= slow ? ({$random(seed)} % 8 == 0) : ({$random(seed)} % 4 != 0);
  end
  // Holds the word until ready and ce are seen at a falling edge, then waits for the rising edge
  task send(input logic [31:0] w);
    logic r;
    cfg_in_valid <= 1'b1;
    cfg_in_data  <= w;
    do begin
      @(negedge clk);
      r = cfg_in_ready && ce;
      @(posedge clk);
    end while (!r);
  endtask
  // One readback: header before sync is junk and must be ignored
  task run(input logic [31:0] frame_address_register, input logic [10:0] cnt, input logic t2, input logic cmd);
    integer n;
    got.delete();
    @(posedge clk);
    send(`FRS_HDR_CMD_WR);
    send(`FRS_SYNC_WORD);
    send(`FRS_HDR_FAR_WR);
    send(frame_address_register);
    if (cmd) begin
      send(`FRS_HDR_CMD_WR);
      send(`FRS_CMD_READ_CONFIGURATION_COMMAND);
    end
    if (t2) begin
      send(`FRS_HDR_FRAME_DATA_OUTPUT_REGISTER_RD);
      send(`FRS_HDR2_TYPE | cnt);
    end else begin
      send(`FRS_HDR_FRAME_DATA_OUTPUT_REGISTER_RD | cnt);
    end
    send(32'h0);
    cfg_in_valid <= 1'b0;
    cfg_in_data  <= 32'hFFFFFFFF;  // Released line shows inverse of flush word
    n = 0;
    while (got.size() < cnt && n < (cmd ? 6000 : 60)) begin
      @(posedge clk);
      n = n + 1;
    end
  endtask
endmodule

/* frs_sequencer.v */
// Frame readback sequencer: packet parser, frame streamer, address mapper and output FIFO
`include "frs_defines.vh"
module frs_sequencer #(
  parameter FRAME_WORDS = `FRS_FRAME_WORDS,
  parameter FIFO_DEPTH  = `FRS_FIFO_DEPTH
) (
  clk,
  rst_n,
  ce,
  cfg_in_valid,
  cfg_in_data,
  cfg_in_ready,
  cfg_mem_addr,
  cfg_mem_data,
  rb_valid,
  rb_ready,
  rb_data,
  rb_busy,
  map_lut_bit,
  map_slice,
  map_frame_bit_index,
  map_major,
  map_minor_address,
  map_frame_word_number,
  map_word_bit_position,
  map_frame_start_word
);
  input  wire        clk;                  // 20 MHz clock
  input  wire        rst_n;                // Asynchronous reset
  input  wire        ce;                   // Clock enable
  input  wire        cfg_in_valid;         // Configuration word strobe
  input  wire [31:0] cfg_in_data;          // Configuration word
  output wire        cfg_in_ready;         // Word accepted
  output reg  [31:0] cfg_mem_addr;         // Frame word fetch address
  input  wire [31:0] cfg_mem_data;         // Stored frame word, one cycle later
  output wire        rb_valid;             // Readback word valid
  input  wire        rb_ready;             // Readback consumer ready
  output wire [31:0] rb_data;              // Readback word
  output reg         rb_busy;              // Read operation running
  input  wire [3:0]  map_lut_bit;          // Table bit 0..15
  input  wire        map_slice;            // Slice select
  input  wire [15:0] map_frame_bit_index;  // Bit index inside frame
  input  wire [7:0]  map_major;            // Logic column major address
  output reg  [7:0]  map_minor_address;    // Minor address of table bit
  output reg  [15:0] map_frame_word_number;// Word inside frame
  output reg  [4:0]  map_word_bit_position;// Bit inside word
  output reg  [31:0] map_frame_start_word; // Word in readback stream
  // ------------------------------------------------------------
  // Parser states
  // ------------------------------------------------------------
  localparam [2:0] ST_SYNC  = 3'h0;
  localparam [2:0] ST_HDR   = 3'h1;
  localparam [2:0] ST_FAR   = 3'h2;
  localparam [2:0] ST_CMD   = 3'h3;
  localparam [2:0] ST_CNT   = 3'h4;
  localparam [2:0] ST_FLUSH = 3'h5;
  localparam [2:0] ST_RUN   = 3'h6;
  localparam [2:0] ST_DRAIN = 3'h7;
  reg [2:0]  st_r;                       // Parser state
  reg [31:0] frame_address_register_r;   // Loaded frame address
  reg        read_configuration_command_armed_r;               // Read command seen
  reg [26:0] words_left_r;               // Words still to send
  reg [26:0] cnt_nxt;                    // Count from read header
  reg [15:0] wcnt_r;                     // Word within frame
  reg        pad_r;                      // Sending leading pad frame
  reg        fetch_r;                    // Memory data valid next cycle
  reg        fetch_pad_r;                // Fetched word is pad
  wire       fifo_ready;
  wire       fifo_valid;
  wire [31:0] fifo_data;
  wire       take;
  assign take         = ce & cfg_in_valid & cfg_in_ready;
  // Stream holds off the host while it runs
  assign cfg_in_ready = (st_r != ST_RUN) && (st_r != ST_DRAIN);
  // ------------------------------------------------------------
  // Read count decode: type-1 short count or following type-2
  // ------------------------------------------------------------
  always @* begin
    cnt_nxt = {16'h0000, cfg_in_data[10:0]};
    if ((cfg_in_data & `FRS_HDR2_MASK) == `FRS_HDR2_TYPE) begin
      cnt_nxt = cfg_in_data[26:0];
    end
  end
  // ------------------------------------------------------------
  // Packet parser and streamer
  // ------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r                     <= ST_SYNC;
      frame_address_register_r <= 32'h00000000;
      read_configuration_command_armed_r             <= 1'b0;
      words_left_r             <= 27'h0000000;
      wcnt_r                   <= 16'h0000;
      pad_r                    <= 1'b0;
      fetch_r                  <= 1'b0;
      fetch_pad_r              <= 1'b0;
      cfg_mem_addr             <= 32'h00000000;
      rb_busy                  <= 1'b0;
    end else if (ce) begin
      fetch_r <= 1'b0;
      case (st_r)
        // Wait for the sync word before any packet
        ST_SYNC: begin
          if (take && cfg_in_data == `FRS_SYNC_WORD) begin
            st_r <= ST_HDR;
          end
        end
        // Dispatch on packet header
        ST_HDR: begin
          if (take) begin
            if (cfg_in_data == `FRS_HDR_FAR_WR) begin
              st_r <= ST_FAR;
            end else if (cfg_in_data == `FRS_HDR_CMD_WR) begin
              st_r <= ST_CMD;
            end else if ((cfg_in_data & `FRS_HDR_RD_MASK) == `FRS_HDR_FRAME_DATA_OUTPUT_REGISTER_RD) begin
              // Only a prior read command makes the read legal
              if (read_configuration_command_armed_r) begin
                if (cfg_in_data[10:0] != 11'h000) begin
                  words_left_r <= cnt_nxt;
                  st_r         <= ST_FLUSH;
                end else begin
                  st_r <= ST_CNT;
                end
              end
            end else if (cfg_in_data == `FRS_SYNC_WORD) begin
              st_r <= ST_HDR;
            end
          end
        end
        // Start frame address word
        ST_FAR: begin
          if (take) begin
            frame_address_register_r <= cfg_in_data;
            read_configuration_command_armed_r             <= 1'b0;
            st_r                     <= ST_HDR;
          end
        end
        // Command register value
        ST_CMD: begin
          if (take) begin
            read_configuration_command_armed_r <= (cfg_in_data == `FRS_CMD_READ_CONFIGURATION_COMMAND);
            st_r         <= ST_HDR;
          end
        end
        // Type-2 word count follows a zero-count header
        ST_CNT: begin
          if (take) begin
            words_left_r <= cnt_nxt;
            st_r         <= ST_FLUSH;
          end
        end
        // Flush word, then the run begins with the pad frame
        ST_FLUSH: begin
          if (take) begin
            st_r         <= (words_left_r == 27'h0000000) ? ST_HDR : ST_RUN;
            rb_busy      <= (words_left_r != 27'h0000000);
            pad_r        <= 1'b1;
            wcnt_r       <= 16'h0000;
            cfg_mem_addr <= frame_address_register_r;
          end
        end
        // One word every other cycle while the FIFO has room
        ST_RUN: begin
          if (fifo_ready && !fetch_r) begin
            fetch_r      <= 1'b1;
            fetch_pad_r  <= pad_r;
            words_left_r <= words_left_r - 1'b1;
            if (wcnt_r == FRAME_WORDS[15:0] - 1'b1) begin
              wcnt_r <= 16'h0000;
              pad_r  <= 1'b0;
            end else begin
              wcnt_r <= wcnt_r + 1'b1;
            end
            if (!pad_r) begin
              cfg_mem_addr <= cfg_mem_addr + 1'b1;
            end
            if (words_left_r == 27'h0000001) begin
              st_r <= ST_DRAIN;
            end
          end
        end
        // Last fetch lands, run is over
        ST_DRAIN: begin
          if (!fetch_r) begin
            rb_busy      <= 1'b0;
            read_configuration_command_armed_r <= 1'b0;
            st_r         <= ST_HDR;
          end
        end
        default: begin
          st_r <= ST_SYNC;
        end
      endcase
    end
  end
  // ------------------------------------------------------------
  // Output buffer; pad words read as zero
  // ------------------------------------------------------------
  frs_fifo #(
    .WIDTH (32),
    .DEPTH (FIFO_DEPTH),
    .AW    (2)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .in_valid  (fetch_r),
    .in_ready  (fifo_ready),
    .in_data   (fetch_pad_r ? 32'h00000000 : cfg_mem_data),
    .out_valid (fifo_valid),
    .out_ready (rb_ready),
    .out_data  (fifo_data)
  );
  // Stored table bits are already the complement of logic values
  assign rb_valid = fifo_valid;
  assign rb_data  = fifo_data;
  // ------------------------------------------------------------
  // Address arithmetic, registered
  // ------------------------------------------------------------
  reg [7:0]  minor_nxt;
  reg [31:0] minor_wide_nxt;    // Minor address before the cut to 8 bits
  reg [15:0] wd_nxt;
  reg [15:0] pos_nxt;
  reg [31:0] start_nxt;
  always @* begin
    if (map_slice) begin
      minor_wide_nxt = `FRS_SLICE1_BASE - {28'h0000000, map_lut_bit};
    end else begin
      minor_wide_nxt = {28'h0000000, map_lut_bit} + `FRS_LUT_OFS;
    end
    // Result never reaches 48, so dropping the upper bits loses nothing
    minor_nxt = minor_wide_nxt[7:0];
    wd_nxt    = map_frame_bit_index >> 5;
    pos_nxt   = 16'd31 + (wd_nxt << 5) - map_frame_bit_index;
    start_nxt = FRAME_WORDS * (`FRS_LEAD_FRAMES + (map_major - 1) * `FRS_COL_FRAMES
                + minor_nxt) + FRAME_WORDS;
  end
  // Map outputs update each enabled cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      map_minor_address     <= 8'h00;
      map_frame_word_number <= 16'h0000;
      map_word_bit_position <= 5'h00;
      map_frame_start_word  <= 32'h00000000;
    end else if (ce) begin
      map_minor_address     <= minor_nxt;
      map_frame_word_number <= wd_nxt;
      map_word_bit_position <= pos_nxt[4:0];
      map_frame_start_word  <= start_nxt;
    end
  end
endmodule

// ------------------------------------------------------------
// Small valid/ready FIFO for readback words
// ------------------------------------------------------------
module frs_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             ce,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  // ------------------------------------------------------------
  // Storage and pointers
  // ------------------------------------------------------------
  reg [WIDTH-1:0] mem_r [0:DEPTH-1]; // Entry storage
  reg [AW-1:0]    wp_r;              // Write pointer
  reg [AW-1:0]    rp_r;              // Read pointer
  reg [AW:0]      cnt_r;             // Occupancy
  wire push;
  wire pop;
  assign in_ready  = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign push      = ce & in_valid & in_ready;
  assign pop       = ce & out_valid & out_ready;
  assign out_data  = mem_r[rp_r];
  // Storage write, no reset needed on data
  always @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
  // Pointer and count update
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
      end
      if (push & ~pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop & ~push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

/* testbench.sv */
// Self-checking testbench for the frame readback sequencer
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int FW = 14;                  // Words per frame
  logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, slow = 1'b0, ce_gap = 1'b0;
  logic        cfg_in_valid, cfg_in_ready, rb_valid, rb_ready, rb_busy;
  logic [31:0] cfg_in_data, cfg_mem_addr, rb_data, map_frame_start_word;
  logic [31:0] cfg_mem_data = 32'h0;
  logic [3:0]  map_lut_bit = 4'h0;
  logic        map_slice = 1'b0;
  logic [15:0] map_frame_bit_index = 16'h0, map_frame_word_number;
  logic [7:0]  map_major = 8'h01, map_minor_address, mn;
  logic [4:0]  map_word_bit_position;
  integer      seed = 44797, num_errors = 0, samples_checked = 0, cycles = 0, i;
  frs_sequencer #(.FRAME_WORDS(FW)) dut (.clk(clk), .rst_n(rst_n), .ce(ce),
    .cfg_in_valid(cfg_in_valid), .cfg_in_data(cfg_in_data), .cfg_in_ready(cfg_in_ready),
    .cfg_mem_addr(cfg_mem_addr), .cfg_mem_data(cfg_mem_data), .rb_valid(rb_valid),
    .rb_ready(rb_ready), .rb_data(rb_data), .rb_busy(rb_busy), .map_lut_bit(map_lut_bit),
    .map_slice(map_slice), .map_frame_bit_index(map_frame_bit_index), .map_major(map_major),
    .map_minor_address(map_minor_address), .map_frame_word_number(map_frame_word_number),
    .map_word_bit_position(map_word_bit_position),
    .map_frame_start_word(map_frame_start_word));
  frs_host u_host (.clk(clk), .ce(ce), .cfg_in_ready(cfg_in_ready),
    .cfg_in_valid(cfg_in_valid), .cfg_in_data(cfg_in_data), .rb_valid(rb_valid),
    .rb_data(rb_data), .rb_ready(rb_ready), .slow(slow));
  // ----------------------------------------------------------
  // Clock, frame store and hang guard
  // ----------------------------------------------------------
  always #25 clk = ~clk;
  // Store holds complemented words, answered on the next enabled edge, as it shares ce
  always @(posedge clk) if (ce) cfg_mem_data <= ~cfg_mem_addr;
  // Clock enable drops at random once gaps are asked for, to prove the freeze
  always @(posedge clk) ce <= !ce_gap || ({$random(seed)} % 4 != 0);
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors = num_errors + 1;
      finish_test;
    end
  end
  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  // Leading pad frame is zero, then words fetched upward from the address
  function automatic logic [31:0] exp_word(input logic [31:0] frame_address_register, input int k);
    exp_word = (k < FW) ? 32'h0 : ~(frame_address_register + k - FW);
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task do_run(input logic [31:0] frame_address_register, input logic [10:0] cnt, input logic t2, input logic cmd);
    integer k;
    u_host.run(frame_address_register, cnt, t2, cmd);
    k = 0;
    while (rb_busy !== 1'b0 && k < 200) begin
      @(posedge clk);
      k = k + 1;
    end
    #1;
    chk(u_host.got.size(), cmd ? cnt : 11'd0);
    for (k = 0; k < u_host.got.size(); k++) chk(u_host.got[k], exp_word(frame_address_register, k));
    chk(cfg_in_ready, 1'b1);
    $display("test run far=%h count=%0d done", frame_address_register, cnt);
  endtask
  task finish_test;
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk(rb_valid, 1'b0);
    chk(cfg_in_ready, 1'b1);
    // Every bit and slice first, then random mapper inputs
    for (i = 0; i < 200; i++) begin
      @(posedge clk);
      map_lut_bit         <= (i < 32) ? i[3:0] : 4'($random(seed));
      map_slice           <= (i < 32) ? i[4] : 1'($random(seed));
      map_frame_bit_index <= 16'($random(seed));
      map_major           <= 8'({$random(seed)} % 255 + 1);
      @(posedge clk);
      #1;
      mn = map_slice ? 8'd15 - map_lut_bit : 8'(map_lut_bit) + 8'd32;
      chk(map_minor_address, mn);
      chk(map_frame_word_number, map_frame_bit_index / 32);
      chk(map_word_bit_position, 5'(31 + 32 * (map_frame_bit_index / 32) - map_frame_bit_index));
      chk(map_frame_start_word, 32'(FW * (8 + (map_major - 1) * 48 + mn) + FW));
    end
    $display("test mapper done");
    do_run(32'h00020000, 11'd238, 1'b0, 1'b1);
    slow <= 1'b1;
    for (i = 0; i < 2; i++) do_run(32'h0002000F - i, 11'd28, 1'b1, 1'b1);
    do_run(32'h00020000, 11'd28, 1'b0, 1'b0);
    ce_gap <= 1'b1;  // Random runs see clock-enable gaps
    for (i = 0; i < 4; i++) begin
      slow <= i[0];
      do_run($random(seed) & 32'h01FFFE00, 11'($random(seed) & 63) + 11'd1, i[1], 1'b1);
    end
    finish_test;
  end
endmodule
